// ==== logic/conv_seq_pkg.sv ====
//
// Purpose: Shared constants and types for the two-pass conversion sequencer
// Assumes: core_clk at 40 MHz
// Notes: Times are kept in ns and converted to whole cycles here
//
package conv_seq_pkg;

    // ****************************************
    // Clock and timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 25;
    localparam int HOLD_DELAY_NS = 50;
    localparam int PHASE1_NS = 3350;
    localparam int SETTLE_NS = 200;
    localparam int PHASE2_NS = 1750;
    localparam int THROUGHPUT_SPS = 166000;
    // Least times round up
    localparam int HOLD_DELAY_CYC = (HOLD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PHASE1_CYC = (PHASE1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PHASE2_CYC = (PHASE2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FRAME_CYC = 1000000000 / (THROUGHPUT_SPS * CLK_PERIOD_NS);
    localparam int CNT_W = 8;

    // ****************************************
    // Data layout
    // ****************************************
    localparam int RES_W = 16;
    localparam int PASS_W = 9;
    localparam int DAC_ZERO_W = 7;
    localparam logic [RES_W-1:0] MIDSCALE = 16'h8000;
    localparam logic [PASS_W-1:0] RESIDUE_OFFSET = 9'h040;

    // ****************************************
    // Sequencer states
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_APERTURE = 3'b001,
        ST_PHASE1 = 3'b010,
        ST_SETTLE = 3'b011,
        ST_PHASE2 = 3'b100,
        ST_CORRECT = 3'b101
    } seq_state_t;

endpackage : conv_seq_pkg

// ==== logic/result_if.sv ====
//
// Purpose: Carries corrected words from sequencer into the result buffer
// Assumes: Single clock domain
// Notes: Valid/ready handshake, word taken when both high
//
`timescale 1ns/10ps
`default_nettype none
interface result_if;
    logic valid;
    logic ready;
    logic [15:0] data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface : result_if
`default_nettype wire

// ==== logic/result_buffer.sv ====
//
// Purpose: Two-entry buffer between correction logic and output latch
// Assumes: Synchronous active-low reset
// Notes: Output side drains whenever out_ready is high
//
`timescale 1ns/10ps
`default_nettype none
module result_buffer
    import conv_seq_pkg::*;
#(
    parameter int WIDTH = 16
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Fill side
    result_if.dst in_port,
    // Drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);

    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;
        logic [1:0] count;
    } buf_state_t;

    buf_state_t s_q;
    buf_state_t s_d;
    logic push;
    logic pop;

    // ****************************************
    // Handshake
    // ****************************************
    assign in_port.ready = (s_q.count != 2'd2);
    assign out_valid = (s_q.count != 2'd0);
    assign out_data = s_q.mem[0];
    assign push = in_port.valid && in_port.ready;
    assign pop = out_valid && out_ready;

    // Shift out at head, write at tail; a simultaneous push and pop keeps the count
    always_comb
    begin
        s_d = s_q;
        if (pop)
        begin
            s_d.mem[0] = s_q.mem[1];
            s_d.count = s_q.count - 2'd1;
        end
        if (push)
        begin
            s_d.mem[s_d.count[0]] = in_port.data;
            s_d.count = s_d.count + 2'd1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

endmodule : result_buffer
`default_nettype wire

// ==== logic/conv_seq.sv ====
//
// Purpose: Sequences one 16-bit two-pass conversion and holds its result
// Assumes: Inputs synchronous to core_clk, 40 MHz
// Notes: The analog flash converter sits outside; this drives its controls
//
// Overview of operation
// - Start on convert_start_n rising edge, enter hold
// - Hold 50 ns after edge, busy low
// - First phase lasts 3.35 us
// - First pass gives 9 MSBs to DAC
// - DAC low 7 bits held at zero
// - Second phase after settling, latch residue
// - Residue hold returns input to sampling
// - Correction merges both passes into 16 bits
// - Throughput 166 kSPS, host respects rate
// - Result in two's complement, midscale at ground
// - Busy low whole conversion, then high
//
`timescale 1ns/10ps
`default_nettype none
module conv_seq
    import conv_seq_pkg::*;
#(
    parameter int PASS_BITS = PASS_W
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Host control
    input wire logic convert_start_n,
    input wire logic chip_select_n,
    input wire logic read_n,
    output logic busy_n,
    output logic [RES_W-1:0] data_out,
    output logic data_oe,
    // Analog front end controls
    output logic input_hold,
    output logic residue_hold,
    output logic [RES_W-1:0] dac_code,
    output logic flash_sample,
    input wire logic [PASS_BITS-1:0] flash_code,
    // Status
    output logic overrun
);

    typedef struct packed {
        seq_state_t state;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] frame;
        logic start_prev;
        logic busy_n;
        logic input_hold;
        logic residue_hold;
        logic [PASS_BITS-1:0] coarse;
        logic [PASS_BITS-1:0] fine;
        logic [RES_W-1:0] word;
        logic word_valid;
        logic [RES_W-1:0] out_latch;
        logic overrun;
    } seq_t;

    seq_t s_q;
    seq_t s_d;
    logic start_edge;
    logic buf_valid;
    logic [RES_W-1:0] buf_data;
    logic host_read;
    logic [RES_W:0] merged;

    result_if res_bus ();

    // ****************************************
    // Result buffer
    // ****************************************
    // Buffer out_ready tied high: it pops every cycle it holds a word, and the output latch loads each one
    result_buffer #(.WIDTH(RES_W)) u_buf (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .in_port(res_bus),
        .out_valid(buf_valid),
        .out_data(buf_data),
        .out_ready(1'b1)
    );

    assign res_bus.valid = s_q.word_valid;
    assign res_bus.data = s_q.word;
    assign start_edge = convert_start_n && !s_q.start_prev;
    assign host_read = !chip_select_n && !read_n;
    // Fine pass overlaps coarse by two bits; offset removed before merge
    assign merged = {1'b0, s_q.coarse, {DAC_ZERO_W{1'b0}}}
        + {{(RES_W+1-PASS_BITS){1'b0}}, s_q.fine}
        - {{(RES_W+1-PASS_BITS){1'b0}}, RESIDUE_OFFSET};

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb
    begin
        s_d = s_q;
        s_d.start_prev = convert_start_n;
        // Word stays offered until the buffer takes it, so a stall drops nothing
        if (res_bus.ready)
            s_d.word_valid = 1'b0;
        if (s_q.frame != '0)
            s_d.frame = s_q.frame - 8'd1;
        if (s_q.cnt != '0)
            s_d.cnt = s_q.cnt - 8'd1;
        // Output latch loads from buffer head
        if (buf_valid)
            s_d.out_latch = buf_data;
        case (s_q.state)
            ST_IDLE:
            begin
                if (start_edge)
                begin
                    s_d.state = ST_APERTURE;
                    s_d.cnt = CNT_W'(HOLD_DELAY_CYC - 1);
                    s_d.frame = CNT_W'(FRAME_CYC - 1);
                    s_d.busy_n = 1'b0;
                    s_d.overrun = (s_q.frame != '0);
                end
            end
            ST_APERTURE:
            begin
                if (s_q.cnt == '0)
                begin
                    s_d.input_hold = 1'b1;
                    s_d.state = ST_PHASE1;
                    s_d.cnt = CNT_W'(PHASE1_CYC - HOLD_DELAY_CYC - 1);
                end
            end
            ST_PHASE1:
            begin
                if (s_q.cnt == '0)
                begin
                    s_d.coarse = flash_code;
                    s_d.state = ST_SETTLE;
                    s_d.cnt = CNT_W'(SETTLE_CYC - 1);
                end
            end
            ST_SETTLE:
            begin
                if (s_q.cnt == '0)
                begin
                    // Residue hold frees the input stage to track again
                    s_d.residue_hold = 1'b1;
                    s_d.input_hold = 1'b0;
                    s_d.state = ST_PHASE2;
                    s_d.cnt = CNT_W'(PHASE2_CYC - 1);
                end
            end
            ST_PHASE2:
            begin
                if (s_q.cnt == '0)
                begin
                    s_d.fine = flash_code;
                    s_d.residue_hold = 1'b0;
                    s_d.state = ST_CORRECT;
                end
            end
            ST_CORRECT:
            begin
                // Flip the MSB: offset-binary to two's complement
                s_d.word = merged[RES_W-1:0] ^ MIDSCALE;
                s_d.word_valid = 1'b1;
                s_d.state = ST_IDLE;
            end
            default:
            begin
                s_d.state = ST_IDLE;
            end
        endcase
        // Busy rises on the same edge that loads the word into the latch
        if (s_q.state == ST_IDLE && !s_q.busy_n && buf_valid && !start_edge)
            s_d.busy_n = 1'b1;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
            s_q.busy_n <= 1'b1;
            s_q.start_prev <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign busy_n = s_q.busy_n;
    assign data_out = s_q.out_latch;
    assign data_oe = host_read;
    assign input_hold = s_q.input_hold;
    assign residue_hold = s_q.residue_hold;
    assign dac_code = {s_q.coarse, {DAC_ZERO_W{1'b0}}};
    assign flash_sample = (s_q.state == ST_PHASE1 || s_q.state == ST_PHASE2) && s_q.cnt == '0;
    assign overrun = s_q.overrun;

    // ****************************************
    // Checks
    // ****************************************
    sequence start_seq;
        $rose(convert_start_n) && s_q.state == ST_IDLE;
    endsequence

    AST_BUSY_ON_START: assert property (@(posedge core_clk) disable iff (!rst_n)
        start_seq |=> !busy_n) else $error("busy not low after start");
    AST_HOLD_DELAY: assert property (@(posedge core_clk) disable iff (!rst_n)
        start_seq |=> !input_hold [*2] ##1 input_hold) else $error("hold delay wrong");
    AST_PHASE1_LEN: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(input_hold) |-> ##[133:140] residue_hold) else $error("phase one length wrong");
    AST_DAC_LOW_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
        dac_code[DAC_ZERO_W-1:0] == '0) else $error("dac low bits not zero");
    AST_RELEASE_INPUT: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(residue_hold) |-> !input_hold) else $error("input not released");
    AST_BUSY_WHOLE: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_q.state != ST_IDLE |-> !busy_n) else $error("busy high mid conversion");
    AST_BUSY_RISE: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_q.state == ST_CORRECT |-> ##[2:4] busy_n) else $error("busy did not rise");
    AST_LATCH_FIRST: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(busy_n) |-> data_out == $past(s_q.word, 2)) else $error("stale result at busy");
    AST_CAPTURE_COARSE: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_q.state == ST_PHASE1 && s_q.cnt == '0 |=> dac_code[RES_W-1:DAC_ZERO_W] == $past(flash_code))
        else $error("coarse code not loaded");

endmodule : conv_seq
`default_nettype wire

// ==== bench/host_model.sv ====
// Purpose: Host side model that starts conversions and reads words
// Assumes: Drives on the falling edge of core_clk
// Notes: Start pulse is low for one cycle, idle level high
`timescale 1ns/10ps
`default_nettype none
module host_model
(
    // Clock
    input wire logic core_clk,
    // Bus to device
    output var logic convert_start_n,
    output var logic chip_select_n,
    output var logic read_n,
    input wire logic [15:0] data_out,
    input wire logic data_oe
);
    // ****************************************
    // Host tasks
    // ****************************************
    // Idle: nothing selected, start line high
    initial
    begin
        convert_start_n = 1'b1;
        chip_select_n = 1'b1;
        read_n = 1'b1;
    end

    // Low then high; the rising edge starts the device
    task start_conv;
        @(negedge core_clk) convert_start_n = 1'b0;
        @(negedge core_clk) convert_start_n = 1'b1;
    endtask : start_conv

    // Select and strobe together; word taken a cycle later
    task read_word(output logic [15:0] w, output logic oe);
        @(negedge core_clk);
        chip_select_n = 1'b0;
        read_n = 1'b0;
        @(negedge core_clk);
        w = data_out;
        oe = data_oe;
        chip_select_n = 1'b1;
        read_n = 1'b1;
    endtask : read_word
endmodule : host_model
`default_nettype wire

// ==== bench/two_pass_adc_conversion_sequencer_tb_top.sv ====
// Purpose: Self-checking bench for the conversion sequencer
// Assumes: 40 MHz core_clk, inputs change on the falling edge
// Notes: The bench plays the flash converter; host_model the host
`timescale 1ns/10ps
`default_nettype none
module two_pass_adc_conversion_sequencer_tb_top;
    import conv_seq_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    wire convert_start_n;
    wire chip_select_n;
    wire read_n;
    logic busy_n, data_oe, input_hold, residue_hold, flash_sample, overrun;
    logic [15:0] data_out, dac_code;
    logic [8:0] flash_code = 9'h000;
    logic [8:0] fine_v = 9'h000;
    logic seen = 1'b0;
    int n_fail = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [8:0] tc [4] = '{9'h100, 9'h000, 9'h1ff, 9'h0aa};
    logic [8:0] tf [4] = '{9'h040, 9'h000, 9'h1ff, 9'h155};

    conv_seq conv_seq_inst (.core_clk(core_clk), .rst_n(rst_n),
        .convert_start_n(convert_start_n), .chip_select_n(chip_select_n),
        .read_n(read_n), .busy_n(busy_n), .data_out(data_out), .data_oe(data_oe),
        .input_hold(input_hold), .residue_hold(residue_hold), .dac_code(dac_code),
        .flash_sample(flash_sample), .flash_code(flash_code), .overrun(overrun));
    host_model host_model_inst (.core_clk(core_clk), .convert_start_n(convert_start_n),
        .chip_select_n(chip_select_n), .read_n(read_n), .data_out(data_out),
        .data_oe(data_oe));

    // Clock, 25 ns period
    initial
    begin
        forever #12.5 core_clk = ~core_clk;
    end

    // Flash converter: coarse code until first capture, then fine code
    always @(negedge core_clk)
    begin
        if (seen) flash_code = fine_v;
        if (flash_sample === 1'b1) seen = 1'b1;
    end

    // Cut a hang short; the run needs about 1700 cycles
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 10000)
        begin
            n_fail++;
            results();
        end
    end

    // ****************************************
    // Compare and report
    // ****************************************
    task chk_word(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task chk_flag(input logic got, input logic exp);
        chk_word({15'h0000, got}, {15'h0000, exp});
    endtask : chk_flag

    task results;
        $display("compares %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results

    // ****************************************
    // Scenarios
    // ****************************************
    // One conversion; again=1 adds a start in mid-conversion that must be ignored
    task sc_convert(input logic [8:0] c, input logic [8:0] f, input bit again);
        int k;
        int t_res;
        logic [15:0] w;
        logic oe;
        logic [15:0] exp;
        exp = (({7'h00, c} << 7) + {7'h00, f} - 16'h0040) ^ 16'h8000;
        flash_code = c;
        fine_v = f;
        seen = 1'b0;
        host_model_inst.start_conv();
        t_res = 0;
        for (k = 1; k < 300; k++)
        begin
            @(negedge core_clk);
            if (k == 2) chk_flag(busy_n, 1'b0);
            if (k == 4) chk_flag(input_hold, 1'b1);
            if (again && k == 60)
            begin
                host_model_inst.start_conv();
                k += 2;
            end
            if (residue_hold === 1'b1 && t_res == 0)
            begin
                t_res = k;
                chk_flag(input_hold, 1'b0);
                chk_word(dac_code, {c, 7'h00});
            end
            if (k > 4 && busy_n === 1'b1) break;
        end
        chk_flag(t_res >= 134 && t_res < 200, 1'b1);
        chk_flag(k < 240, 1'b1);
        host_model_inst.read_word(w, oe);
        chk_word(w, exp);
        chk_flag(oe, 1'b1);
        // Let the released strobes reach the enable before looking
        #1;
        chk_flag(data_oe, 1'b0);
        if (!again) chk_flag(overrun, 1'b0);
        // Keep starts 254 cycles apart, more than the 240-cycle frame
        repeat (250 - k) @(negedge core_clk);
    endtask : sc_convert

    // Start again right after busy rises: too soon for the rate
    task sc_overrun;
        int k;
        host_model_inst.start_conv();
        for (k = 0; k < 300 && !(k > 4 && busy_n === 1'b1); k++) @(negedge core_clk);
        host_model_inst.start_conv();
        repeat (4) @(negedge core_clk);
        chk_flag(overrun, 1'b1);
        for (k = 0; k < 300 && !(k > 4 && busy_n === 1'b1); k++) @(negedge core_clk);
        chk_flag(busy_n, 1'b1);
    endtask : sc_overrun

    // Main sequence
    initial
    begin
        repeat (6) @(negedge core_clk);
        rst_n = 1'b1;
        @(negedge core_clk);
        chk_flag(busy_n, 1'b1);
        chk_word(data_out, 16'h0000);
        chk_word(dac_code, 16'h0000);
        for (int i = 0; i < 4; i++) sc_convert(tc[i], tf[i], 1'b0);
        sc_convert(9'h0f3, 9'h07c, 1'b1);
        sc_overrun();
        results();
    end
endmodule : two_pass_adc_conversion_sequencer_tb_top
`default_nettype wire
